// ### design/peq_pkg.sv
// Shared constants and carrier types for the polled event retrieval controller.
// Assumes an APB master on the register side and a message-level link to the event responder.
`default_nettype none
package peq_pkg;
   // ----------------------------------------------------------------
   // poll message encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] PEQ_FORMAT_REV = 8'h01;
   typedef enum logic [7:0] {
      PEQ_OP_NEXT = 8'h00,
      PEQ_OP_FIRST = 8'h01,
      PEQ_OP_ACK_ONLY = 8'h02
   } peq_op_t;
   localparam logic [7:0] PEQ_FLAG_START = 8'h00;
   localparam logic [7:0] PEQ_FLAG_MIDDLE = 8'h01;
   localparam logic [7:0] PEQ_FLAG_END = 8'h04;
   localparam logic [7:0] PEQ_FLAG_SINGLE = 8'h05;
   localparam logic [15:0] PEQ_EVT_NONE = 16'h0000;
   localparam logic [15:0] PEQ_EVT_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] PEQ_CC_SUCCESS = 8'h00;
   // ----------------------------------------------------------------
   // register map (byte offsets) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] PEQ_OFF_CTRL = 8'h00;
   localparam logic [7:0] PEQ_OFF_CMD = 8'h04;
   localparam logic [7:0] PEQ_OFF_CHUNK = 8'h08;
   localparam logic [7:0] PEQ_OFF_STATUS = 8'h0C;
   localparam logic [7:0] PEQ_OFF_EVENT = 8'h10;
   localparam logic [7:0] PEQ_OFF_RESULT = 8'h14;
   localparam logic [7:0] PEQ_OFF_BUF_IDX = 8'h18;
   localparam logic [7:0] PEQ_OFF_BUF_DATA = 8'h1C;
   localparam logic [7:0] PEQ_OFF_WORDS = 8'h20;
   localparam logic [7:0] PEQ_OFF_HANDLE = 8'h24;
   localparam int PEQ_CTRL_EN = 0;
   localparam int PEQ_CMD_ACK_ONLY = 0;
   localparam int PEQ_ST_DONE = 0;
   localparam int PEQ_ST_EMPTY = 1;
   localparam int PEQ_ST_CSUM_OK = 2;
   localparam int PEQ_ST_ERR_CC = 3;
   localparam int PEQ_ST_ERR_SIZE = 4;
   localparam int PEQ_ST_ERR_OVF = 5;
   localparam int PEQ_ST_QUEUED = 6;
   localparam int PEQ_ST_W = 7;
   localparam int PEQ_ST_BUSY = 7;
   localparam int PEQ_ST_PEND = 8;
   localparam logic [15:0] PEQ_CHUNK_RST = 16'h0004;
   // ----------------------------------------------------------------
   // link carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] format_revision;
      peq_op_t op;
      logic [31:0] chunk_handle;
      logic [15:0] ack_event_number;
   } peq_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] completion_result;
      logic [7:0] terminus_number;
      logic [15:0] event_number;
      logic [31:0] next_chunk_handle;
      logic [7:0] chunk_position_flag;
      logic [7:0] event_category;
      logic [31:0] payload_checksum;
   } peq_rsp_t;
   typedef struct packed {
      logic valid;
      logic last;
      logic [31:0] word;
   } peq_beat_t;
endpackage
`default_nettype wire

// ### design/peq_csum.sv
// Running payload checksum: 32-bit wrap-around sum of payload words.
// Assumes clear and add are never asserted together.
`default_nettype none
module peq_csum import peq_pkg::*; (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic clr_i,
   input wire logic add_i,
   input wire logic [31:0] word_i,
   output logic [31:0] sum_o
);
   typedef struct packed {
      logic [31:0] sum;
   } peq_csum_state_t;
   peq_csum_state_t r, n;

   always_comb begin
      n = r;
      if (clr_i) begin
         n.sum = '0;
      end else if (add_i) begin
         n.sum = r.sum + word_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign sum_o = r.sum;
endmodule
`default_nettype wire

// ### design/peq_store.sv
// Reassembly buffer for one event payload, one 32-bit word per entry.
// Assumes the writer keeps the address in range; read is combinational.
`default_nettype none
module peq_store import peq_pkg::*; #(
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [31:0] rd_data_o
);
   typedef struct packed {
      logic [(1<<AW)-1:0][31:0] mem;
   } peq_store_state_t;
   peq_store_state_t r, n;

   always_comb begin
      n = r;
      if (wr_en_i) begin
         n.mem[wr_addr_i] = wr_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign rd_data_o = r.mem[rd_addr_i];
endmodule
`default_nettype wire

// ### design/peq_host.sv
// Event receiver controller: polls the event responder, reassembles chunked payloads, acknowledges.
// Assumes an APB master for software and a responder that answers each request with one header.
`default_nettype none
module peq_host import peq_pkg::*; #(
   parameter int BUF_AW = 4
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   output peq_req_t req_o,
   input wire logic req_ready_i,
   input wire peq_rsp_t rsp_i,
   input wire peq_beat_t beat_i,
   output logic busy_o
);
   localparam int BUF_DEPTH = 1 << BUF_AW;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_HDR, ST_DATA, ST_CHECK} peq_st_t;
   typedef struct packed {
      peq_st_t st;
      logic enable;
      logic [15:0] chunk_words;
      logic pend_valid;
      logic [15:0] pend_event;
      logic [15:0] event_number;
      logic [7:0] category;
      logic [7:0] result;
      logic [7:0] flag;
      logic [31:0] handle;
      logic [31:0] far_csum;
      logic [15:0] count;
      logic [15:0] beats;
      logic [PEQ_ST_W-1:0] sticky;
      logic [BUF_AW-1:0] buf_idx;
      peq_req_t req;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic busy;
   } peq_state_t;
   peq_state_t r, n;

   logic sum_clr;
   logic sum_add;
   logic [31:0] sum;
   logic [31:0] buf_word;
   logic room;
   logic wr_en;

   function automatic logic peq_mapped(input logic [7:0] a);
      return a inside {PEQ_OFF_CTRL, PEQ_OFF_CMD, PEQ_OFF_CHUNK, PEQ_OFF_STATUS, PEQ_OFF_EVENT,
                       PEQ_OFF_RESULT, PEQ_OFF_BUF_IDX, PEQ_OFF_BUF_DATA, PEQ_OFF_WORDS, PEQ_OFF_HANDLE};
   endfunction

   function automatic logic peq_more(input logic [7:0] f);
      return f == PEQ_FLAG_START || f == PEQ_FLAG_MIDDLE;
   endfunction

   assign room = r.count < 16'(BUF_DEPTH);
   assign wr_en = r.st == ST_DATA && beat_i.valid && room;

   // ----------------------------------------------------------------
   // register access and poll sequencing
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      sum_clr = 1'b0;
      sum_add = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      // no wait state: answer is prepared in setup, shown in access
      if (psel_i && !penable_i) begin
         n.pready = 1'b1;
         n.pslverr = !peq_mapped(paddr_i);
         case (paddr_i)
            PEQ_OFF_CTRL: n.prdata = 32'(r.enable);
            PEQ_OFF_CHUNK: n.prdata = 32'(r.chunk_words);
            PEQ_OFF_STATUS: n.prdata = 32'({r.pend_valid, r.busy, r.sticky});
            PEQ_OFF_EVENT: n.prdata = {8'h00, r.category, r.event_number};
            PEQ_OFF_RESULT: n.prdata = {16'h0000, r.flag, r.result};
            PEQ_OFF_BUF_IDX: n.prdata = 32'(r.buf_idx);
            PEQ_OFF_BUF_DATA: n.prdata = buf_word;
            PEQ_OFF_WORDS: n.prdata = 32'(r.count);
            PEQ_OFF_HANDLE: n.prdata = r.handle;
            default: n.prdata = '0;
         endcase
      end
      if (psel_i && penable_i && r.pready && pwrite_i) begin
         case (paddr_i)
            PEQ_OFF_CTRL: n.enable = pwdata_i[PEQ_CTRL_EN];
            PEQ_OFF_CHUNK: n.chunk_words = pwdata_i[15:0];
            PEQ_OFF_STATUS: n.sticky = r.sticky & ~pwdata_i[PEQ_ST_W-1:0];
            PEQ_OFF_BUF_IDX: n.buf_idx = pwdata_i[BUF_AW-1:0];
            PEQ_OFF_CMD: begin
               // software enables only after receiver setup has turned polling on
               if (r.st == ST_IDLE && r.enable) begin
                  n.req.valid = 1'b1;
                  n.req.format_revision = PEQ_FORMAT_REV;
                  n.req.chunk_handle = '0;
                  n.req.ack_event_number = r.pend_valid ? r.pend_event : PEQ_EVT_NONE;
                  n.req.op = pwdata_i[PEQ_CMD_ACK_ONLY] ? PEQ_OP_ACK_ONLY : PEQ_OP_FIRST;
                  n.st = ST_SEND;
                  n.busy = 1'b1;
                  n.count = '0;
                  n.beats = '0;
                  n.sticky[PEQ_ST_CSUM_OK] = 1'b0;
                  sum_clr = 1'b1;
               end
            end
            default: ;
         endcase
      end
      case (r.st)
         ST_IDLE: ;
         ST_SEND: begin
            if (req_ready_i) begin
               n.req.valid = 1'b0;
               n.st = ST_HDR;
            end
         end
         ST_HDR: begin
            if (rsp_i.valid) begin
               n.result = rsp_i.completion_result;
               n.event_number = rsp_i.event_number;
               if (rsp_i.completion_result != PEQ_CC_SUCCESS) begin
                  // failed answer carries no payload, and the acknowledge stays owed
                  n.sticky[PEQ_ST_ERR_CC] = 1'b1;
                  n.sticky[PEQ_ST_DONE] = 1'b1;
                  n.busy = 1'b0;
                  n.st = ST_IDLE;
               end else begin
                  if (r.req.op != PEQ_OP_NEXT) begin
                     n.pend_valid = 1'b0;
                  end
                  if (rsp_i.event_number == PEQ_EVT_NONE) begin
                     n.sticky[PEQ_ST_EMPTY] = 1'b1;
                     n.sticky[PEQ_ST_DONE] = 1'b1;
                     n.busy = 1'b0;
                     n.st = ST_IDLE;
                  end else if (rsp_i.event_number == PEQ_EVT_ALL_ONES) begin
                     // queue not empty after acknowledge-only; no handle or flag to read
                     n.sticky[PEQ_ST_QUEUED] = 1'b1;
                     n.sticky[PEQ_ST_DONE] = 1'b1;
                     n.busy = 1'b0;
                     n.st = ST_IDLE;
                  end else begin
                     n.category = rsp_i.event_category;
                     n.flag = rsp_i.chunk_position_flag;
                     n.handle = rsp_i.next_chunk_handle;
                     n.far_csum = rsp_i.payload_checksum;
                     n.beats = '0;
                     n.st = ST_DATA;
                  end
               end
            end
         end
         ST_DATA: begin
            if (beat_i.valid) begin
               sum_add = 1'b1;
               n.beats = r.beats + 16'h0001;
               if (room) begin
                  n.count = r.count + 16'h0001;
               end else begin
                  n.sticky[PEQ_ST_ERR_OVF] = 1'b1;
               end
               if (beat_i.last) begin
                  if (peq_more(r.flag)) begin
                     if (r.beats + 16'h0001 != r.chunk_words) begin
                        n.sticky[PEQ_ST_ERR_SIZE] = 1'b1;
                     end
                     n.req.valid = 1'b1;
                     n.req.op = PEQ_OP_NEXT;
                     n.req.chunk_handle = r.handle;
                     n.req.ack_event_number = PEQ_EVT_ALL_ONES;
                     n.st = ST_SEND;
                  end else begin
                     n.st = ST_CHECK;
                  end
               end
            end
         end
         ST_CHECK: begin
            // an event failing its checksum is left unacknowledged so it comes back
            if (sum == r.far_csum) begin
               n.sticky[PEQ_ST_CSUM_OK] = 1'b1;
               n.pend_valid = 1'b1;
               n.pend_event = r.event_number;
            end
            n.sticky[PEQ_ST_DONE] = 1'b1;
            n.busy = 1'b0;
            n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '{st: ST_IDLE, chunk_words: PEQ_CHUNK_RST, req: '{op: PEQ_OP_FIRST, default: '0}, default: '0};
      end else if (ce_i) begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // payload checksum and reassembly buffer
   // ----------------------------------------------------------------
   peq_csum u_csum (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .clr_i(sum_clr),
      .add_i(sum_add),
      .word_i(beat_i.word),
      .sum_o(sum)
   );

   peq_store #(.AW(BUF_AW)) u_store (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .wr_en_i(wr_en),
      .wr_addr_i(r.count[BUF_AW-1:0]),
      .wr_data_i(beat_i.word),
      .rd_addr_i(r.buf_idx),
      .rd_data_o(buf_word)
   );

   assign pready_o = r.pready;
   assign prdata_o = r.prdata;
   assign pslverr_o = r.pslverr;
   assign req_o = r.req;
   assign busy_o = r.busy;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_format;
      req_o.valid |-> req_o.format_revision == PEQ_FORMAT_REV;
   endproperty
   a_format: assert property (p_format) else $error("format revision not one");

   property p_op_legal;
      req_o.valid |-> req_o.op inside {PEQ_OP_NEXT, PEQ_OP_FIRST, PEQ_OP_ACK_ONLY};
   endproperty
   a_op_legal: assert property (p_op_legal) else $error("illegal operation code");

   property p_next_ack;
      req_o.valid && req_o.op == PEQ_OP_NEXT |-> req_o.ack_event_number == PEQ_EVT_ALL_ONES;
   endproperty
   a_next_ack: assert property (p_next_ack) else $error("fetch-next without all-ones ack");

   property p_next_handle;
      ce_i && r.st == ST_DATA && beat_i.valid && beat_i.last && peq_more(r.flag)
         |=> req_o.valid && req_o.op == PEQ_OP_NEXT && req_o.chunk_handle == $past(r.handle);
   endproperty
   a_next_handle: assert property (p_next_handle) else $error("next chunk not requested by handle");

   property p_hold;
      req_o.valid && !(ce_i && req_ready_i) |=> req_o.valid && $stable(req_o);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed before taken");

   property p_first_ack;
      $rose(req_o.valid) && req_o.op != PEQ_OP_NEXT
         |-> req_o.ack_event_number == (r.pend_valid ? r.pend_event : PEQ_EVT_NONE);
   endproperty
   a_first_ack: assert property (p_first_ack) else $error("poll does not ack retrieved event");

   property p_good_csum;
      ce_i && r.st == ST_CHECK && sum == r.far_csum
         |=> r.pend_valid && r.pend_event == $past(r.event_number) && !r.busy;
   endproperty
   a_good_csum: assert property (p_good_csum) else $error("checked event not queued for ack");

   property p_bad_csum;
      ce_i && r.st == ST_CHECK && sum != r.far_csum |=> !r.pend_valid && !r.sticky[PEQ_ST_CSUM_OK];
   endproperty
   a_bad_csum: assert property (p_bad_csum) else $error("event acked despite bad checksum");

   property p_empty;
      ce_i && r.st == ST_HDR && rsp_i.valid && rsp_i.completion_result == PEQ_CC_SUCCESS
         && rsp_i.event_number == PEQ_EVT_NONE |=> r.sticky[PEQ_ST_EMPTY] && !busy_o && r.st == ST_IDLE;
   endproperty
   a_empty: assert property (p_empty) else $error("empty queue not reported");

   property p_size;
      ce_i && r.st == ST_DATA && beat_i.valid && beat_i.last && peq_more(r.flag)
         && r.beats + 16'h0001 != r.chunk_words |=> r.sticky[PEQ_ST_ERR_SIZE];
   endproperty
   a_size: assert property (p_size) else $error("short chunk not flagged");

   property p_cc_keep;
      ce_i && r.st == ST_HDR && rsp_i.valid && rsp_i.completion_result != PEQ_CC_SUCCESS
         |=> r.pend_valid == $past(r.pend_valid) && r.sticky[PEQ_ST_ERR_CC] && !busy_o;
   endproperty
   a_cc_keep: assert property (p_cc_keep) else $error("failed answer dropped owed acknowledge");

   property p_queued;
      ce_i && r.st == ST_HDR && rsp_i.valid && rsp_i.completion_result == PEQ_CC_SUCCESS
         && rsp_i.event_number == PEQ_EVT_ALL_ONES
         |=> r.sticky[PEQ_ST_QUEUED] && r.st == ST_IDLE && !r.pend_valid;
   endproperty
   a_queued: assert property (p_queued) else $error("queue non-empty answer not reported");
endmodule
`default_nettype wire

// ### dv/peq_resp_model.sv
// Behavioural event responder: keeps a small event queue and answers poll requests with headers and beats.
// Assumes one request at a time from the controller; the bench loads events through push().
`default_nettype none
module peq_resp_model import peq_pkg::*; (
   input wire logic clk_i,
   input wire peq_req_t req_i,
   input wire logic slow_i,
   input wire logic [1:0] fault_i,
   input wire logic [15:0] chunk_i,
   output logic req_ready_o,
   output peq_rsp_t rsp_o,
   output peq_beat_t beat_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEPTH = 3;
   localparam logic [7:0] CAT = 8'h05;
   logic [15:0] evq[$];
   int len[int];
   peq_req_t req_log[$];
   logic [15:0] next_num = 16'h0001;
   logic [31:0] garb = 32'h5A5A5A5A;
   // ----------------------------------------------------------------
   // queue and answer loop
   // ----------------------------------------------------------------
   task automatic push(input int n);
      if (evq.size() == DEPTH) void'(evq.pop_front());
      evq.push_back(next_num);
      len[int'(next_num)] = n;
      next_num = next_num + 16'h0001;
   endtask
   initial begin
      peq_req_t r;
      peq_rsp_t p;
      int c, w, n, cs;
      logic [15:0] id;
      logic [31:0] s;
      req_ready_o = 1'b0;
      rsp_o = '0;
      beat_o = '0;
      forever begin
         @(posedge clk_i);
         if (req_i.valid === 1'b1) begin
            repeat (slow_i ? 4 : 0) @(posedge clk_i);
            req_ready_o <= 1'b1;
            @(posedge clk_i);
            r = req_i;
            req_log.push_back(r);
            req_ready_o <= 1'b0;
            if (evq.size() > 0 && r.ack_event_number != PEQ_EVT_NONE && r.ack_event_number == evq[0])
               void'(evq.pop_front());
            cs = int'(chunk_i);
            c = (r.op == PEQ_OP_NEXT) ? int'(r.chunk_handle) : 0;
            id = (evq.size() == 0) ? PEQ_EVT_NONE : (r.op == PEQ_OP_ACK_ONLY) ? PEQ_EVT_ALL_ONES : evq[0];
            n = (id == PEQ_EVT_NONE || id == PEQ_EVT_ALL_ONES) ? 0 : len[int'(id)];
            w = (n - c * cs < cs) ? n - c * cs : cs;
            s = 32'h00000000;
            for (int i = 0; i < n; i++) s = s + {id, 16'(i)};
            // omitted fields carry junk that changes every answer, never a stale value
            garb = ~garb;
            p = {1'b1, (fault_i == 2'd1) ? 8'h80 : PEQ_CC_SUCCESS, 8'h00, id, garb, garb[7:0], garb[15:8], garb};
            if (n > 0) begin
               p.next_chunk_handle = 32'(c + 1);
               p.chunk_position_flag = (c == 0) ? (((c + 1) * cs < n) ? PEQ_FLAG_START : PEQ_FLAG_SINGLE)
                  : (((c + 1) * cs < n) ? PEQ_FLAG_MIDDLE : PEQ_FLAG_END);
               if (fault_i != 2'd1) begin
                  p.event_category = CAT;
                  p.payload_checksum = (fault_i == 2'd2) ? s + 32'h1 : s;
               end
            end
            @(posedge clk_i);
            rsp_o <= p;
            if (n > 0 && fault_i != 2'd1) begin
               for (int i = 0; i < w; i++) begin
                  @(posedge clk_i);
                  rsp_o.valid <= 1'b0;
                  beat_o <= {1'b1, i == w - 1, id, 16'(c * cs + i)};
               end
            end
            @(posedge clk_i);
            rsp_o.valid <= 1'b0;
            beat_o <= '0;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_polled_event_queue_responder.sv
// Self-checking bench for the poll controller: APB tasks drive commands, the responder model answers.
// Assumes the responder model numbers events from one upwards and uses chunk size 4.
`default_nettype none
module tb_polled_event_queue_responder import peq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err, slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, q;
   logic [1:0] fault = 2'd0;
   logic pready, pslverr, req_ready, busy;
   logic [31:0] prdata;
   peq_req_t req;
   peq_rsp_t rsp;
   peq_beat_t beat;
   int error_cnt = 0, cmp_count = 0, cyc = 0, tnum = 0;
   peq_host dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .req_o(req), .req_ready_i(req_ready), .rsp_i(rsp), .beat_i(beat), .busy_o(busy));
   peq_resp_model u_resp (.clk_i(clk_i), .req_i(req), .slow_i(slow), .fault_i(fault), .chunk_i(PEQ_CHUNK_RST),
      .req_ready_o(req_ready), .rsp_o(rsp), .beat_o(beat));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   initial forever #25 clk_i = ~clk_i;
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // no wait bound here: only the bench timeout ends a stuck access
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q & mask, exp);
   endtask
   // command write, then wait for the controller to finish under a bound
   task automatic cmd(input logic [31:0] d, input logic bexp);
      int n;
      n = 0;
      apb(1'b1, PEQ_OFF_STATUS, 32'h0000007F);
      apb(1'b1, PEQ_OFF_CMD, d);
      chk(32'(busy), 32'(bexp));
      while (busy !== 1'b0 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(busy), 32'h0);
   endtask
   function automatic logic [31:0] rq(input int i);
      peq_req_t r;
      r = u_resp.req_log[i];
      return {r.format_revision, r.op, r.ack_event_number};
   endfunction
   task automatic endt();
      tnum++;
      $display("test %0d done", tnum);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      rchk(PEQ_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
      rchk(PEQ_OFF_CHUNK, 32'hFFFFFFFF, 32'h00000004);
      rchk(PEQ_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
      rchk(8'h30, 32'hFFFFFFFF, 32'h0);
      chk(32'(last_err), 32'h1);
      cmd(32'h0, 1'b0);
      chk(32'(u_resp.req_log.size()), 32'h0);
      endt();
      u_resp.push(2);
      u_resp.push(6);
      apb(1'b1, PEQ_OFF_CTRL, 32'h00000001);
      cmd(32'h0, 1'b1);
      chk(rq(0), {PEQ_FORMAT_REV, PEQ_OP_FIRST, PEQ_EVT_NONE});
      rchk(PEQ_OFF_STATUS, 32'h17F, 32'h105);
      rchk(PEQ_OFF_EVENT, 32'hFFFFFFFF, 32'h00050001);
      rchk(PEQ_OFF_WORDS, 32'hFFFFFFFF, 32'h00000002);
      apb(1'b1, PEQ_OFF_BUF_IDX, 32'h00000001);
      rchk(PEQ_OFF_BUF_DATA, 32'hFFFFFFFF, 32'h00010001);
      endt();
      slow <= 1'b1;
      cmd(32'h0, 1'b1);
      chk(rq(1), {PEQ_FORMAT_REV, PEQ_OP_FIRST, 16'h0001});
      chk(rq(2), {PEQ_FORMAT_REV, PEQ_OP_NEXT, PEQ_EVT_ALL_ONES});
      chk(u_resp.req_log[2].chunk_handle, 32'h00000001);
      rchk(PEQ_OFF_STATUS, 32'h7F, 32'h05);
      rchk(PEQ_OFF_WORDS, 32'hFFFFFFFF, 32'h00000006);
      rchk(PEQ_OFF_RESULT, 32'hFFFF, 32'h0400);
      rchk(PEQ_OFF_HANDLE, 32'hFFFFFFFF, 32'h00000002);
      slow <= 1'b0;
      endt();
      u_resp.push(1);
      u_resp.push(1);
      cmd(32'h1, 1'b1);
      chk(rq(3), {PEQ_FORMAT_REV, PEQ_OP_ACK_ONLY, 16'h0002});
      rchk(PEQ_OFF_STATUS, 32'h40, 32'h40);
      endt();
      fault <= 2'd2;
      cmd(32'h0, 1'b1);
      rchk(PEQ_OFF_STATUS, 32'h05, 32'h01);
      fault <= 2'd0;
      cmd(32'h0, 1'b1);
      chk(rq(5), {PEQ_FORMAT_REV, PEQ_OP_FIRST, PEQ_EVT_NONE});
      rchk(PEQ_OFF_EVENT, 32'hFFFFFFFF, 32'h00050003);
      rchk(PEQ_OFF_STATUS, 32'h7F, 32'h05);
      endt();
      fault <= 2'd1;
      cmd(32'h0, 1'b1);
      chk(rq(6), {PEQ_FORMAT_REV, PEQ_OP_FIRST, 16'h0003});
      rchk(PEQ_OFF_STATUS, 32'h08, 32'h08);
      fault <= 2'd0;
      cmd(32'h0, 1'b1);
      chk(rq(7), {PEQ_FORMAT_REV, PEQ_OP_FIRST, 16'h0003});
      cmd(32'h0, 1'b1);
      chk(rq(8), {PEQ_FORMAT_REV, PEQ_OP_FIRST, 16'h0004});
      rchk(PEQ_OFF_STATUS, 32'h02, 32'h02);
      endt();
      // seventeen words: start, three middles, end, and one word past the buffer
      u_resp.push(17);
      cmd(32'h0, 1'b1);
      chk(rq(9), {PEQ_FORMAT_REV, PEQ_OP_FIRST, PEQ_EVT_NONE});
      chk(rq(11), {PEQ_FORMAT_REV, PEQ_OP_NEXT, PEQ_EVT_ALL_ONES});
      chk(u_resp.req_log[13].chunk_handle, 32'h00000004);
      chk(32'(u_resp.req_log.size()), 32'h0000000E);
      rchk(PEQ_OFF_STATUS, 32'h7F, 32'h25);
      rchk(PEQ_OFF_WORDS, 32'hFFFFFFFF, 32'h00000010);
      endt();
      // controller told three words while the responder still sends four
      apb(1'b1, PEQ_OFF_CHUNK, 32'h00000003);
      rchk(PEQ_OFF_CHUNK, 32'hFFFFFFFF, 32'h00000003);
      u_resp.push(5);
      cmd(32'h0, 1'b1);
      chk(rq(14), {PEQ_FORMAT_REV, PEQ_OP_FIRST, 16'h0005});
      rchk(PEQ_OFF_STATUS, 32'h15, 32'h15);
      apb(1'b1, 8'h30, 32'hFFFFFFFF);
      chk(32'(last_err), 32'h1);
      endt();
      close_out();
   end
endmodule
`default_nettype wire
